// ==== bit_sync.sv ====
// Two flip-flop synchroniser for pin inputs
`timescale 1ns/1ps
module bit_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             clk_i,
    input  wire logic             arst_n_i,
    input  wire logic [WIDTH-1:0] async_i,
    output logic      [WIDTH-1:0] sync_o
);
    logic [WIDTH-1:0] meta_r;
    logic [WIDTH-1:0] meta_nxt;
    logic [WIDTH-1:0] sync_nxt;

    always_comb begin
        meta_nxt = async_i;
        sync_nxt = meta_r;
    end

    // Idle bus level is high, so reset to ones avoids a false start
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            meta_r <= '1;
            sync_o <= '1;
        end else begin
            meta_r <= meta_nxt;
            sync_o <= sync_nxt;
        end
    end
endmodule // bit_sync

// ==== cfg_byte_reg.sv ====
// One 8-bit configuration register with reset value and writable mask
`timescale 1ns/1ps
module cfg_byte_reg #(
    parameter logic [7:0] RST_VAL = 8'h00,
    parameter logic [7:0] WR_MASK = 8'hFF
) (
    input  wire logic       clk_i,
    input  wire logic       arst_n_i,
    input  wire logic       we_i,
    input  wire logic [7:0] wdata_i,
    output logic      [7:0] q_o
);
    logic [7:0] q_nxt;

    always_comb begin
        q_nxt = q_o;
        if (we_i) begin
            q_nxt = wdata_i & WR_MASK;
        end
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            q_o <= RST_VAL & WR_MASK;
        end else begin
            q_o <= q_nxt;
        end
    end
endmodule // cfg_byte_reg

// ==== pll_cfg_pkg.sv ====
// Constants, register map and state type for the loop configuration bank
package pll_cfg_pkg;

    // ------------------------------------------------------------------
    // Register offsets on the serial management port
    // ------------------------------------------------------------------
    localparam logic [7:0] OFS_FRAC_MOD   = 8'h21;
    localparam logic [7:0] OFS_LOOP_FIRST = 8'h22;
    localparam logic [7:0] OFS_LOOP_SECND = 8'h23;
    localparam logic [7:0] OFS_LF_R2      = 8'h24;
    localparam int         NUM_REGS       = 4;

    // ------------------------------------------------------------------
    // Reset values and writable-bit masks (unmasked bits read zero)
    // ------------------------------------------------------------------
    localparam logic [7:0] RST_FRAC_MOD   = 8'h0C;
    localparam logic [7:0] RST_LOOP_FIRST = 8'h28;
    localparam logic [7:0] RST_LOOP_SECND = 8'h03;
    localparam logic [7:0] RST_LF_R2      = 8'h00;
    localparam logic [7:0] MSK_FRAC_MOD   = 8'h0F;
    localparam logic [7:0] MSK_LOOP_FIRST = 8'hEF;
    localparam logic [7:0] MSK_LOOP_SECND = 8'h77;
    localparam logic [7:0] MSK_LF_R2      = 8'hFF;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int DITHER_LSB  = 2;
    localparam int DITHER_W    = 2;
    localparam int ORDER_LSB   = 0;
    localparam int ORDER_W     = 2;
    localparam int DOUBLER_BIT = 5;
    localparam int PUMP_LSB    = 0;
    localparam int PUMP_W      = 4;
    localparam int PHASE_LSB   = 4;
    localparam int PHASE_W     = 3;
    localparam int C3_BIT      = 2;
    localparam int RESV_LSB    = 0;
    localparam int RESV_W      = 2;

    localparam logic [1:0] DITHER_RST = 2'h3;
    localparam logic [1:0] RESV_RST   = 2'h3;

    // ------------------------------------------------------------------
    // Serial port framing
    // ------------------------------------------------------------------
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;
    localparam logic [6:0] DEV_ADDR_DFLT = 7'h2A;

    typedef enum logic [4:0] {
        ST_IDLE   = 5'h01,
        ST_RX     = 5'h02,
        ST_ACK_TX = 5'h04,
        ST_TX     = 5'h08,
        ST_ACK_RX = 5'h10
    } port_state_type;

    typedef enum logic [2:0] {
        PH_ADDR = 3'h1,
        PH_PTR  = 3'h2,
        PH_DATA = 3'h4
    } byte_phase_type;

endpackage

// ==== pll_loop_config_regs.sv ====
// Loop configuration register bank behind a serial management port slave
//
// Functional notes
// - Dither mode field bits 3:2 of fractional register, resets 3; 0 weak, 3 off.
// - Modulator order field bits 1:0 of fractional register, resets 0; 0 integer, 3 third.
// - Doubler enable bit 5 of first loop register, resets 1, enables doubler.
// - Pump current code bits 3:0 of first loop register, resets 0x8.
// - Pump phase delay code bits 6:4 of second loop register, resets 0.
// - Third-order filter enable bit 2 of second loop register, resets 0.
// - Eight-bit resistor two code fills the whole resistor register.
// - Reserved low bits of second loop register reset to 3.
`timescale 1ns/1ps
module pll_loop_config_regs
    import pll_cfg_pkg::*;
#(
    parameter logic [6:0] DEV_ADDR = pll_cfg_pkg::DEV_ADDR_DFLT
) (
    input  wire logic       clk_i,
    input  wire logic       arst_n_i,
    input  wire logic       scl_i,
    input  wire logic       sda_i,
    output logic            sda_o,
    output logic            sda_oe_n_o,
    output logic [1:0]      dither_mode_sel_o,
    output logic [1:0]      mod_order_o,
    output logic            doubler_en_o,
    output logic [3:0]      pump_current_code_o,
    output logic [2:0]      pump_phase_delay_code_o,
    output logic            third_order_filter_en_o,
    output logic [7:0]      filter_resistor_two_code_o
);
    import pll_cfg_pkg::*;

    // ------------------------------------------------------------------
    // Pin synchronisers and bus conditions
    // ------------------------------------------------------------------
    logic [1:0] pin_sync;
    logic       scl_s;
    logic       sda_s;
    logic       scl_d_r;
    logic       sda_d_r;

    bit_sync #(.WIDTH(2)) u_sync (
        .clk_i    (clk_i),
        .arst_n_i (arst_n_i),
        .async_i  ({scl_i, sda_i}),
        .sync_o   (pin_sync)
    );

    assign scl_s = pin_sync[1];
    assign sda_s = pin_sync[0];

    logic start_c;
    logic stop_c;
    logic scl_rise;
    logic scl_fall;

    assign start_c  = scl_s & scl_d_r & sda_d_r & ~sda_s;
    assign stop_c   = scl_s & scl_d_r & ~sda_d_r & sda_s;
    assign scl_rise = scl_s & ~scl_d_r;
    assign scl_fall = ~scl_s & scl_d_r;

    // ------------------------------------------------------------------
    // Register file
    // ------------------------------------------------------------------
    function automatic logic hit(input logic [7:0] ptr, input logic [7:0] ofs);
        hit = (ptr == ofs);
    endfunction

    logic [7:0]          reg_q [NUM_REGS];
    logic [NUM_REGS-1:0] reg_we;
    logic [7:0]          wdata;
    logic                wr_c;
    logic [7:0]          ptr_r;
    logic [7:0]          shift_r;

    assign wdata     = shift_r;
    assign reg_we[0] = wr_c & hit(ptr_r, OFS_FRAC_MOD);
    assign reg_we[1] = wr_c & hit(ptr_r, OFS_LOOP_FIRST);
    assign reg_we[2] = wr_c & hit(ptr_r, OFS_LOOP_SECND);
    assign reg_we[3] = wr_c & hit(ptr_r, OFS_LF_R2);

    cfg_byte_reg #(.RST_VAL(RST_FRAC_MOD), .WR_MASK(MSK_FRAC_MOD)) u_frac (
        .clk_i (clk_i), .arst_n_i (arst_n_i), .we_i (reg_we[0]), .wdata_i (wdata), .q_o (reg_q[0])
    );
    cfg_byte_reg #(.RST_VAL(RST_LOOP_FIRST), .WR_MASK(MSK_LOOP_FIRST)) u_loop1 (
        .clk_i (clk_i), .arst_n_i (arst_n_i), .we_i (reg_we[1]), .wdata_i (wdata), .q_o (reg_q[1])
    );
    cfg_byte_reg #(.RST_VAL(RST_LOOP_SECND), .WR_MASK(MSK_LOOP_SECND)) u_loop2 (
        .clk_i (clk_i), .arst_n_i (arst_n_i), .we_i (reg_we[2]), .wdata_i (wdata), .q_o (reg_q[2])
    );
    cfg_byte_reg #(.RST_VAL(RST_LF_R2), .WR_MASK(MSK_LF_R2)) u_lfr2 (
        .clk_i (clk_i), .arst_n_i (arst_n_i), .we_i (reg_we[3]), .wdata_i (wdata), .q_o (reg_q[3])
    );

    assign dither_mode_sel_o          = reg_q[0][DITHER_LSB +: DITHER_W];
    assign mod_order_o                = reg_q[0][ORDER_LSB +: ORDER_W];
    assign doubler_en_o               = reg_q[1][DOUBLER_BIT];
    assign pump_current_code_o        = reg_q[1][PUMP_LSB +: PUMP_W];
    assign pump_phase_delay_code_o    = reg_q[2][PHASE_LSB +: PHASE_W];
    assign third_order_filter_en_o    = reg_q[2][C3_BIT];
    assign filter_resistor_two_code_o = reg_q[3];

    // Unmapped pointers read as zero and swallow writes
    function automatic logic [7:0] rd_byte(input logic [7:0] ptr);
        rd_byte = 8'h00;
        if (hit(ptr, OFS_FRAC_MOD))   rd_byte = reg_q[0];
        if (hit(ptr, OFS_LOOP_FIRST)) rd_byte = reg_q[1];
        if (hit(ptr, OFS_LOOP_SECND)) rd_byte = reg_q[2];
        if (hit(ptr, OFS_LF_R2))      rd_byte = reg_q[3];
    endfunction

    // ------------------------------------------------------------------
    // Serial slave state machine
    // ------------------------------------------------------------------
    port_state_type state_r, state_nxt;
    byte_phase_type phase_r, phase_nxt;
    logic [7:0]     shift_nxt;
    logic [7:0]     ptr_nxt;
    logic [3:0]     cnt_r, cnt_nxt;
    logic           rd_r, rd_nxt;
    logic           nack_r, nack_nxt;
    logic           oe_n_nxt;
    logic [7:0]     rd_now;

    // A process, not an assign, so that register updates also refresh the read byte
    always_comb begin
        rd_now = rd_byte(ptr_r);
    end
    assign wr_c   = (state_r == ST_RX) & scl_fall & (cnt_r == BITS_PER_BYTE) & (phase_r == PH_DATA);

    always_comb begin
        state_nxt = state_r;
        phase_nxt = phase_r;
        shift_nxt = shift_r;
        ptr_nxt   = ptr_r;
        cnt_nxt   = cnt_r;
        rd_nxt    = rd_r;
        nack_nxt  = nack_r;
        oe_n_nxt  = sda_oe_n_o;
        if (start_c) begin
            state_nxt = ST_RX;
            phase_nxt = PH_ADDR;
            cnt_nxt   = 4'h0;
            oe_n_nxt  = 1'b1;
        end else if (stop_c) begin
            state_nxt = ST_IDLE;
            oe_n_nxt  = 1'b1;
        end else begin
            case (state_r)
                ST_RX: begin
                    if (scl_rise && cnt_r != BITS_PER_BYTE) begin
                        shift_nxt = {shift_r[6:0], sda_s};
                        cnt_nxt   = cnt_r + 4'h1;
                    end else if (scl_fall && cnt_r == BITS_PER_BYTE) begin
                        state_nxt = ST_ACK_TX;
                        oe_n_nxt  = 1'b0;
                        case (phase_r)
                            PH_ADDR: begin
                                rd_nxt = shift_r[0];
                                if (shift_r[7:1] != DEV_ADDR) begin
                                    state_nxt = ST_IDLE;
                                    oe_n_nxt  = 1'b1;
                                end
                            end
                            PH_PTR:  ptr_nxt = shift_r;
                            default: ptr_nxt = ptr_r + 8'h01;
                        endcase
                    end
                end
                ST_ACK_TX: begin
                    if (scl_fall) begin
                        cnt_nxt = 4'h0;
                        if (phase_r == PH_ADDR && rd_r) begin
                            state_nxt = ST_TX;
                            shift_nxt = rd_now;
                            oe_n_nxt  = rd_now[7];
                            ptr_nxt   = ptr_r + 8'h01;
                        end else begin
                            state_nxt = ST_RX;
                            oe_n_nxt  = 1'b1;
                            phase_nxt = (phase_r == PH_ADDR) ? PH_PTR : PH_DATA;
                        end
                    end
                end
                ST_TX: begin
                    if (scl_rise) begin
                        cnt_nxt = cnt_r + 4'h1;
                    end else if (scl_fall) begin
                        if (cnt_r == BITS_PER_BYTE) begin
                            state_nxt = ST_ACK_RX;
                            oe_n_nxt  = 1'b1;
                        end else begin
                            shift_nxt = {shift_r[6:0], 1'b0};
                            oe_n_nxt  = shift_r[6];
                        end
                    end
                end
                ST_ACK_RX: begin
                    if (scl_rise) begin
                        nack_nxt = sda_s;
                    end else if (scl_fall) begin
                        cnt_nxt = 4'h0;
                        if (nack_r) begin
                            state_nxt = ST_IDLE;
                        end else begin
                            state_nxt = ST_TX;
                            shift_nxt = rd_now;
                            oe_n_nxt  = rd_now[7];
                            ptr_nxt   = ptr_r + 8'h01;
                        end
                    end
                end
                default: begin
                    state_nxt = ST_IDLE;
                    oe_n_nxt  = 1'b1;
                end
            endcase
        end
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            state_r    <= ST_IDLE;
            phase_r    <= PH_ADDR;
            shift_r    <= 8'h00;
            ptr_r      <= 8'h00;
            cnt_r      <= 4'h0;
            rd_r       <= 1'b0;
            nack_r     <= 1'b0;
            sda_oe_n_o <= 1'b1;
            sda_o      <= 1'b0;
            scl_d_r    <= 1'b1;
            sda_d_r    <= 1'b1;
        end else begin
            state_r    <= state_nxt;
            phase_r    <= phase_nxt;
            shift_r    <= shift_nxt;
            ptr_r      <= ptr_nxt;
            cnt_r      <= cnt_nxt;
            rd_r       <= rd_nxt;
            nack_r     <= nack_nxt;
            sda_oe_n_o <= oe_n_nxt;
            sda_o      <= 1'b0;
            scl_d_r    <= scl_s;
            sda_d_r    <= sda_s;
        end
    end

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    logic [NUM_REGS-1:0] wr_seen_r;

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            wr_seen_r <= '0;
        end else begin
            wr_seen_r <= wr_seen_r | reg_we;
        end
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!arst_n_i);

    a_dither_reset_hold: assert property (!wr_seen_r[0] |-> dither_mode_sel_o == DITHER_RST)
        else $error("dither mode lost its reset value");
    a_order_write_track: assert property (reg_we[0] |=> mod_order_o == $past(wdata[1:0]))
        else $error("modulator order did not take written value");
    a_doubler_reset_on: assert property (!wr_seen_r[1] |-> doubler_en_o)
        else $error("doubler not enabled out of reset");
    a_pump_write_track: assert property (reg_we[1] |=> pump_current_code_o == $past(wdata[PUMP_LSB +: PUMP_W]))
        else $error("pump current code wrong after write");
    a_phase_hold_stable: assert property (!reg_we[2] |=> $stable(pump_phase_delay_code_o))
        else $error("phase delay code changed without a write");
    a_c3_reset_off: assert property (!wr_seen_r[2] |-> !third_order_filter_en_o)
        else $error("third order filter enabled out of reset");
    a_resistor_write_track: assert property (reg_we[3] |=> filter_resistor_two_code_o == $past(wdata))
        else $error("resistor code did not take written byte");
    a_resv_low_reset: assert property (!wr_seen_r[2] |-> reg_q[2][RESV_LSB +: RESV_W] == RESV_RST)
        else $error("reserved low bits lost reset value");

    // Each field follows the byte written to it on the next clock, and holds while no write occurs
    a_dither_write_track: assert property (reg_we[0] |=> dither_mode_sel_o == $past(wdata[DITHER_LSB +: DITHER_W]))
        else $error("dither mode did not take written value");
    a_doubler_write_track: assert property (reg_we[1] |=> doubler_en_o == $past(wdata[DOUBLER_BIT]))
        else $error("doubler enable did not take written value");
    a_doubler_hold_stable: assert property (!reg_we[1] |=> $stable(doubler_en_o))
        else $error("doubler enable changed without a write");
    a_phase_write_track: assert property (reg_we[2] |=> pump_phase_delay_code_o == $past(wdata[PHASE_LSB +: PHASE_W]))
        else $error("phase delay code did not take written value");
    a_c3_write_track: assert property (reg_we[2] |=> third_order_filter_en_o == $past(wdata[C3_BIT]))
        else $error("third order filter enable did not take written value");
    a_resistor_hold_stable: assert property (!reg_we[3] |=> $stable(filter_resistor_two_code_o))
        else $error("resistor code changed without a write");
    a_resv_write_track: assert property (reg_we[2] |=> reg_q[2][RESV_LSB +: RESV_W] == $past(wdata[RESV_LSB +: RESV_W]))
        else $error("reserved low bits did not take written value");

    c_write_first_loop: cover property (reg_we[1]);
    c_read_byte_sent: cover property (state_r == ST_ACK_TX ##[1:40] state_r == ST_TX);
    c_read_ends_nack: cover property (state_r == ST_ACK_RX && nack_r ##[1:40] state_r == ST_IDLE);
    c_stop_seen: cover property (stop_c);

endmodule // pll_loop_config_regs

// ==== smp_host_model.sv ====
// Host model that reaches the loop configuration bank over the serial management port
`timescale 1ns/1ps
module smp_host_model
    import pll_cfg_pkg::*;
#(
    parameter logic [6:0] DEV_ADDR = pll_cfg_pkg::DEV_ADDR_DFLT
) (
    input  wire logic clk_i,
    input  wire logic sda_i,
    output logic      scl_o,
    output logic      sda_low_o
);
    initial begin
        scl_o     = 1'h1;
        sda_low_o = 1'h0;
    end

    // ------------------------------------------------------------------
    // Bus phases
    // ------------------------------------------------------------------
    // Six clocks per phase stays clear of the four-clock minimum
    task automatic half();
        repeat (6) @(posedge clk_i);
        #1;
    endtask

    task automatic bit_cyc(input logic b, output logic r);
        sda_low_o = ~b;
        half();
        scl_o = 1'h1;
        half();
        r = sda_i;
        scl_o = 1'h0;
        // Data moves only once the low clock level is through the synchronisers
        repeat (2) @(posedge clk_i);
        #1;
    endtask

    task automatic byte_cyc(input logic [7:0] w, input logic rel, output logic [7:0] r, output logic ack);
        logic a;
        for (int i = 7; i >= 0; i--) begin
            bit_cyc(w[i], a);
            r[i] = a;
        end
        bit_cyc(rel, a);
        ack = ~a;
    endtask

    // Also serves as repeated start: release data first, then raise the clock
    task automatic start_cond();
        sda_low_o = 1'h0;
        half();
        scl_o = 1'h1;
        half();
        sda_low_o = 1'h1;
        half();
        scl_o = 1'h0;
        repeat (2) @(posedge clk_i);
        #1;
    endtask

    task automatic stop_cond();
        sda_low_o = 1'h1;
        half();
        scl_o = 1'h1;
        half();
        sda_low_o = 1'h0;
        half();
    endtask

    task automatic wr(input logic [7:0] ptr, input logic [7:0] d, output logic ok);
        logic [7:0] r;
        logic       a0;
        logic       a1;
        logic       a2;
        start_cond();
        byte_cyc({DEV_ADDR, 1'h0}, 1'h1, r, a0);
        byte_cyc(ptr, 1'h1, r, a1);
        byte_cyc(d, 1'h1, r, a2);
        stop_cond();
        ok = a0 & a1 & a2;
    endtask

    // Single byte read ends with a master not-acknowledge
    task automatic rd(input logic [7:0] ptr, output logic [7:0] d, output logic ok);
        logic [7:0] r;
        logic       a0;
        logic       a1;
        logic       a2;
        logic       a3;
        start_cond();
        byte_cyc({DEV_ADDR, 1'h0}, 1'h1, r, a0);
        byte_cyc(ptr, 1'h1, r, a1);
        start_cond();
        byte_cyc({DEV_ADDR, 1'h1}, 1'h1, r, a2);
        byte_cyc(8'hFF, 1'h1, d, a3);
        stop_cond();
        ok = a0 & a1 & a2;
    endtask
endmodule // smp_host_model

// ==== tb_top.sv ====
// Self-checking bench for the loop configuration register bank
`timescale 1ns/1ps
module tb_top;
    import pll_cfg_pkg::*;
    logic       clk_i = 1'h0;
    logic       arst_n_i = 1'h0;
    logic       scl_w;
    logic       host_low;
    logic       sda_w;
    logic       sda_o;
    logic       sda_oe_n_o;
    logic       dbl;
    logic       c3;
    logic [1:0] dith;
    logic [1:0] ord;
    logic [3:0] pump;
    logic [2:0] ph;
    logic [7:0] r2;
    int         mismatches = 0;
    int         checks_done = 0;

    always #5 clk_i = ~clk_i;

    // Open-drain data line with pull-up: low while either side pulls it
    assign sda_w = ~(host_low | (~sda_oe_n_o & ~sda_o));

    pll_loop_config_regs i_dut (.clk_i(clk_i), .arst_n_i(arst_n_i), .scl_i(scl_w), .sda_i(sda_w),
        .sda_o(sda_o), .sda_oe_n_o(sda_oe_n_o), .dither_mode_sel_o(dith), .mod_order_o(ord),
        .doubler_en_o(dbl), .pump_current_code_o(pump), .pump_phase_delay_code_o(ph),
        .third_order_filter_en_o(c3), .filter_resistor_two_code_o(r2));
    smp_host_model i_host (.clk_i(clk_i), .sda_i(sda_w), .scl_o(scl_w), .sda_low_o(host_low));

    // ------------------------------------------------------------------
    // Shared checks and register access
    // ------------------------------------------------------------------
    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
        checks_done++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch at %0t ns: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] ptr, input logic [7:0] d);
        logic ok;
        i_host.wr(ptr, d, ok);
        chk({7'h00, ok}, 8'h01, "write acknowledge");
    endtask

    task automatic rd_chk(input logic [7:0] ptr, input logic [7:0] exp);
        logic       ok;
        logic [7:0] d;
        i_host.rd(ptr, d, ok);
        chk({7'h00, ok}, 8'h01, "read acknowledge");
        chk(d, exp, "register readback");
    endtask

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic t_reset_values();
        chk({6'h00, dith}, 8'h03, "dither mode");
        chk({6'h00, ord}, 8'h00, "modulator order");
        chk({7'h00, dbl}, 8'h01, "doubler enable");
        chk({4'h0, pump}, 8'h08, "pump current");
        chk({5'h00, ph}, 8'h00, "phase delay");
        chk({7'h00, c3}, 8'h00, "third order filter");
        chk(r2, 8'h00, "resistor code");
        rd_chk(OFS_FRAC_MOD, {4'h0, 2'h3, 2'h0});
        rd_chk(OFS_LOOP_FIRST, {2'h0, 1'h1, 1'h0, 4'h8});
        rd_chk(OFS_LOOP_SECND, {1'h0, 3'h0, 1'h0, 1'h0, 2'h3});
        rd_chk(OFS_LF_R2, 8'h00);
    endtask

    task automatic t_modulator();
        logic [1:0] codes[2] = '{2'h0, 2'h3};
        for (int i = 0; i < 4; i++) begin
            wr(OFS_FRAC_MOD, {4'h0, codes[i/2], codes[i%2]});
            chk({6'h00, dith}, {6'h00, codes[i/2]}, "dither mode");
            chk({6'h00, ord}, {6'h00, codes[i%2]}, "modulator order");
            rd_chk(OFS_FRAC_MOD, {4'h0, codes[i/2], codes[i%2]});
        end
    endtask

    task automatic t_loop_first();
        logic [3:0] pc;
        for (int i = 0; i < 4; i++) begin
            pc = (i % 2 == 1) ? 4'h8 : 4'h4;
            wr(OFS_LOOP_FIRST, {2'h0, i[1], 1'h0, pc});
            chk({7'h00, dbl}, {7'h00, i[1]}, "doubler enable");
            chk({4'h0, pump}, {4'h0, pc}, "pump current");
            rd_chk(OFS_LOOP_FIRST, {2'h0, i[1], 1'h0, pc});
        end
    endtask

    task automatic t_loop_second();
        for (int i = 0; i < 8; i++) begin
            wr(OFS_LOOP_SECND, {1'h0, i[2:0], 1'h0, i[0], 2'h3});
            chk({5'h00, ph}, {5'h00, i[2:0]}, "phase delay");
            chk({7'h00, c3}, {7'h00, i[0]}, "third order filter");
            rd_chk(OFS_LOOP_SECND, {1'h0, i[2:0], 1'h0, i[0], 2'h3});
        end
    endtask

    task automatic t_resistor();
        logic [7:0] codes[8] = '{8'h01, 8'h04, 8'h08, 8'h20, 8'h30, 8'h40, 8'hFF, 8'h5A};
        foreach (codes[i]) begin
            wr(OFS_LF_R2, codes[i]);
            chk(r2, codes[i], "resistor code");
            rd_chk(OFS_LF_R2, codes[i]);
        end
    endtask

    // Move the dither, doubler and pump fields, which the earlier scenarios left at reset, away from it
    task automatic t_mid_reset();
        wr(OFS_FRAC_MOD, {4'h0, 2'h0, 2'h3});
        wr(OFS_LOOP_FIRST, {2'h0, 1'h0, 1'h0, 4'h4});
        @(posedge clk_i);
        #1 arst_n_i = 1'h0;
        repeat (3) @(posedge clk_i);
        #1 arst_n_i = 1'h1;
        t_reset_values();
    endtask

    task automatic tally_and_finish();
        if (mismatches == 0 && checks_done > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    initial begin
        repeat (20) @(posedge clk_i);
        #1 arst_n_i = 1'h1;
        t_reset_values();
        t_modulator();
        t_loop_first();
        t_loop_second();
        t_resistor();
        t_mid_reset();
        tally_and_finish();
    end

    // About sixty transactions of about five microseconds each fit well inside this
    initial begin
        #800000;
        mismatches++;
        tally_and_finish();
    end
endmodule // tb_top
